// *** src/ahl_defines.svh ***
`ifndef AHL_DEFINES_SVH
`define AHL_DEFINES_SVH

// word framing on the serial link
`define AHL_WORD_BITS   24
`define AHL_BYTE_BITS   8
`define AHL_CNT_W       5

// system clock and serial clock timing, in ns
`define AHL_CLK_NS      40
`define AHL_SCLK_NS     320
// half serial period in system cycles, rounded down (shortest time)
`define AHL_HALF_CYC    ((`AHL_SCLK_NS / 2) / `AHL_CLK_NS)
// least strobe-high time between byte segments, rounded up
`define AHL_GAP_NS      320
`define AHL_GAP_CYC     ((`AHL_GAP_NS + `AHL_CLK_NS - 1) / `AHL_CLK_NS)

// segment size codes on seg_bytes_in
`define AHL_SEG_WHOLE   2'h0
`define AHL_SEG_ONE     2'h1
`define AHL_SEG_TWO     2'h2

`endif

// *** src/ahl_pkg.sv ***
package ahl_pkg;

  // sequencer states, gray along idle-wait-shift-gap-done
  typedef enum logic [2:0] {
    AHL_IDLE  = 3'h0,
    AHL_WAIT  = 3'h1,
    AHL_SHIFT = 3'h3,
    AHL_GAP   = 3'h2,
    AHL_DONE  = 3'h6
  } ahl_state_e;

  // transfer kinds requested by the user side
  typedef enum logic [2:0] {
    AHL_RD_DATA = 3'h0,
    AHL_RD_CTRL = 3'h1,
    AHL_RD_CAL  = 3'h2,
    AHL_WR_CTRL = 3'h3,
    AHL_WR_CAL  = 3'h4
  } ahl_kind_e;

endpackage

// *** src/ahl_sclk_div.sv ***
// serial clock divider: idles low, first half period low after run rises
module ahl_sclk_div
  import ahl_pkg::*;
#(
  parameter int HALF_CYC = 4
) (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  // control
  input  wire logic run_in,
  // serial clock and edge pulses
  output logic      sclk_out,
  output logic      rise_out,
  output logic      fall_out
);

  localparam int CW = $clog2(HALF_CYC) + 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  logic [CW-1:0] cnt_ff;
  logic          sclk_ff;
  logic          tick;

  // a tick ends each half period while running
  assign tick     = run_in && (cnt_ff == LAST);
  assign rise_out = ce_in && tick && !sclk_ff;
  assign fall_out = ce_in && tick && sclk_ff;
  assign sclk_out = sclk_ff;

  // half period counter, cleared when stopped so each segment starts clean
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
    end else if (ce_in) begin
      if (!run_in || tick) begin
        cnt_ff <= '0;
      end else begin
        cnt_ff <= cnt_ff + CW'(1);
      end
    end
  end

  // clock level; stopping forces low so the line idles low between frames
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_ff <= 1'b0;
    end else if (ce_in) begin
      if (!run_in) begin
        sclk_ff <= 1'b0;
      end else if (tick) begin
        sclk_ff <= !sclk_ff;
      end
    end
  end

endmodule

// *** src/ahl_host.sv ***
// Behaviour
// - with write strobe wired to select, every write is a control register load.
// - in that wiring a control register read is refused, never attempted.
// - write strobe may be the inverse of read strobe; strobes never overlap.
// - read strobe is never derived from the write strobe; both are driven apart.
// - output-data reads wait for word-ready low before lowering read strobe.
// - a 24-bit read may be split into one, two or three byte frames.
// - control and calibration reads ignore word-ready.
// - control register read lowers select together with the read strobe.
// - host sends written data MSB first.
// - every register write sends a full 24-bit word.
// - with LSB-first user data, bits are reversed within each byte.
// - read: wait ready low, lower strobe, take bytes, raise after last byte.
`include "ahl_defines.svh"

module ahl_host
  import ahl_pkg::*;
#(
  parameter int WORD_BITS = `AHL_WORD_BITS,
  parameter int HALF_CYC  = `AHL_HALF_CYC,
  parameter int GAP_CYC   = `AHL_GAP_CYC
) (
  // clock, reset, enable
  input  wire logic                 mclk_in,
  input  wire logic                 rst_in,
  input  wire logic                 ce_in,
  // configuration levels
  input  wire logic                 tie_sel_in,
  input  wire logic                 lsb_first_in,
  input  wire logic [1:0]           seg_bytes_in,
  // user command side
  input  wire logic                 cmd_valid_in,
  output logic                      cmd_ready_out,
  input  wire logic [2:0]           cmd_kind_in,
  input  wire logic [WORD_BITS-1:0] cmd_wdata_in,
  output logic [WORD_BITS-1:0]      rdata_out,
  output logic                      rdata_valid_out,
  output logic                      cmd_err_out,
  // converter pins
  output logic                      sclk_out,
  output logic                      read_frame_n_out,
  output logic                      write_frame_n_out,
  output logic                      reg_select_out,
  input  wire logic                 word_ready_n_in,
  input  wire logic                 sdata_in,
  output logic                      sdata_out,
  output logic                      sdata_oe_n_out
);

  localparam logic [`AHL_CNT_W-1:0] LAST_BIT = `AHL_CNT_W'(WORD_BITS);
  localparam int GW = $clog2(GAP_CYC + 1) + 1;

  // reverse bit order inside each byte, used on both directions
  function automatic logic [WORD_BITS-1:0] rev_bytes(input logic [WORD_BITS-1:0] w);
    logic [WORD_BITS-1:0] r;
    r = '0;
    for (int i = 0; i < WORD_BITS; i++) begin
      r[i] = w[(i / `AHL_BYTE_BITS) * `AHL_BYTE_BITS + (`AHL_BYTE_BITS - 1)
               - (i % `AHL_BYTE_BITS)];
    end
    return r;
  endfunction

  ahl_state_e                state_ff;
  ahl_state_e                nxt_state;
  ahl_kind_e                 kind_ff;
  logic [WORD_BITS-1:0]      word_ff;
  logic [WORD_BITS-1:0]      sh_ff;
  logic [`AHL_CNT_W-1:0]     bit_cnt_ff;
  logic [`AHL_CNT_W-1:0]     seg_cnt_ff;
  logic [`AHL_CNT_W-1:0]     seg_bits;
  logic [GW-1:0]             gap_cnt_ff;
  logic                      rdy_meta_ff;
  logic                      rdy_sync_ff;
  logic                      sd_meta_ff;
  logic                      sd_sync_ff;
  logic                      rd_n_ff;
  logic                      wr_n_ff;
  logic                      sel_ff;
  logic                      oe_n_ff;
  logic                      is_wr;
  logic                      take;
  logic                      refuse;
  logic                      run;
  logic                      sclk_rise;
  logic                      sclk_fall;
  logic                      seg_end;

  // word-ready pin into the clock domain
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdy_meta_ff <= 1'b1;
      rdy_sync_ff <= 1'b1;
    end else if (ce_in) begin
      rdy_meta_ff <= word_ready_n_in;
      rdy_sync_ff <= rdy_meta_ff;
    end
  end

  // serial data pin into the clock domain; half period of 4 cycles covers the lag
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sd_meta_ff <= 1'b0;
      sd_sync_ff <= 1'b0;
    end else if (ce_in) begin
      sd_meta_ff <= sdata_in;
      sd_sync_ff <= sd_meta_ff;
    end
  end

  // command acceptance and the wiring-dependent refusals
  assign cmd_ready_out = (state_ff == AHL_IDLE);
  assign take          = ce_in && cmd_valid_in && cmd_ready_out;
  assign refuse        = tie_sel_in && ((cmd_kind_in == AHL_RD_CTRL)
                         || (cmd_kind_in == AHL_WR_CAL)
                         || (cmd_kind_in > AHL_WR_CAL));
  assign is_wr         = (kind_ff == AHL_WR_CTRL) || (kind_ff == AHL_WR_CAL);

  // bits per strobe-low segment
  always_comb begin
    case (seg_bytes_in)
      `AHL_SEG_ONE: seg_bits = `AHL_CNT_W'(`AHL_BYTE_BITS);
      `AHL_SEG_TWO: seg_bits = `AHL_CNT_W'(2 * `AHL_BYTE_BITS);
      default:      seg_bits = LAST_BIT;
    endcase
  end

  assign seg_end = sclk_fall && (seg_cnt_ff + `AHL_CNT_W'(1) == seg_bits);

  // sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      AHL_IDLE: begin
        if (take && !refuse) begin
          nxt_state = AHL_WAIT;
        end
      end
      AHL_WAIT: begin
        // only output data waits for a fresh word; others go at once
        if (kind_ff != AHL_RD_DATA || !rdy_sync_ff) begin
          nxt_state = AHL_SHIFT;
        end
      end
      AHL_SHIFT: begin
        if (sclk_fall && bit_cnt_ff + `AHL_CNT_W'(1) == LAST_BIT) begin
          nxt_state = AHL_DONE;
        end else if (seg_end) begin
          nxt_state = AHL_GAP;
        end
      end
      AHL_GAP: begin
        if (gap_cnt_ff == GW'(GAP_CYC)) begin
          nxt_state = AHL_SHIFT;
        end
      end
      AHL_DONE: nxt_state = AHL_IDLE;
      default:  nxt_state = AHL_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= AHL_IDLE;
    end else if (ce_in) begin
      state_ff <= nxt_state;
    end
  end

  // kind and word are latched once per command
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      kind_ff <= AHL_RD_DATA;
      word_ff <= '0;
    end else if (take && !refuse) begin
      kind_ff <= ahl_kind_e'(cmd_kind_in);
      word_ff <= lsb_first_in ? rev_bytes(cmd_wdata_in) : cmd_wdata_in;
    end
  end

  // refused command answered by a one-cycle error pulse
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_err_out <= 1'b0;
    end else if (ce_in) begin
      cmd_err_out <= take && refuse;
    end
  end

  // serial clock runs only in the shift state
  assign run = (state_ff == AHL_SHIFT);

  ahl_sclk_div #(
    .HALF_CYC (HALF_CYC)
  ) u_div (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .run_in   (run),
    .sclk_out (sclk_out),
    .rise_out (sclk_rise),
    .fall_out (sclk_fall)
  );

  // bit and segment counters advance on each falling clock
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_cnt_ff <= '0;
      seg_cnt_ff <= '0;
    end else if (ce_in) begin
      if (state_ff == AHL_IDLE) begin
        bit_cnt_ff <= '0;
        seg_cnt_ff <= '0;
      end else if (seg_end) begin
        bit_cnt_ff <= bit_cnt_ff + `AHL_CNT_W'(1);
        seg_cnt_ff <= '0;
      end else if (sclk_fall) begin
        bit_cnt_ff <= bit_cnt_ff + `AHL_CNT_W'(1);
        seg_cnt_ff <= seg_cnt_ff + `AHL_CNT_W'(1);
      end
    end
  end

  // strobe-high time between segments
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      gap_cnt_ff <= '0;
    end else if (ce_in) begin
      gap_cnt_ff <= (state_ff == AHL_GAP) ? gap_cnt_ff + GW'(1) : '0;
    end
  end

  // shifter: writes shift out MSB first, reads sample at the falling clock
  // where the previous bit has been stable for a whole high half
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sh_ff <= '0;
    end else if (ce_in) begin
      if (state_ff == AHL_WAIT) begin
        sh_ff <= is_wr ? word_ff : '0;
      end else if (sclk_fall) begin
        sh_ff <= {sh_ff[WORD_BITS-2:0], is_wr ? 1'b0 : sd_sync_ff};
      end
    end
  end

  // pin drivers, one cycle behind state so strobes lead the first clock edge
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      sel_ff  <= 1'b1;
      oe_n_ff <= 1'b1;
    end else if (ce_in) begin
      // read and write strobes driven apart, never both low
      rd_n_ff <= !(run && !is_wr);
      wr_n_ff <= !(run && is_wr);
      oe_n_ff <= !(run && is_wr);
      if (tie_sel_in) begin
        sel_ff <= !(run && is_wr);
      end else begin
        // held for the whole transfer, gaps included
        sel_ff <= !((run || state_ff == AHL_GAP) &&
                   (kind_ff == AHL_RD_CTRL || kind_ff == AHL_WR_CTRL));
      end
    end
  end

  assign read_frame_n_out  = rd_n_ff;
  assign write_frame_n_out = wr_n_ff;
  assign reg_select_out    = sel_ff;
  assign sdata_oe_n_out    = oe_n_ff;
  assign sdata_out         = sh_ff[WORD_BITS-1];

  // read result presented once the whole word is in
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out       <= '0;
      rdata_valid_out <= 1'b0;
    end else if (ce_in) begin
      rdata_valid_out <= (state_ff == AHL_DONE) && !is_wr;
      if (state_ff == AHL_DONE && !is_wr) begin
        rdata_out <= lsb_first_in ? rev_bytes(sh_ff) : sh_ff;
      end
    end
  end

  // checks
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence wait_leave_s;
    state_ff == AHL_WAIT && nxt_state == AHL_SHIFT && ce_in;
  endsequence

  sequence word_finish_s;
    state_ff == AHL_SHIFT && nxt_state == AHL_DONE && ce_in;
  endsequence

  strobes_apart_a: assert property (read_frame_n_out || write_frame_n_out)
    else $error("read and write strobes low together");

  idle_levels_a: assert property (state_ff == AHL_IDLE |->
    read_frame_n_out && write_frame_n_out && !sclk_out)
    else $error("idle levels wrong");

  ready_wait_a: assert property (wait_leave_s and kind_ff == AHL_RD_DATA
    |-> !rdy_sync_ff ##1 1 ##1 !read_frame_n_out)
    else $error("data read started without word ready");

  ctrl_select_a: assert property ($fell(read_frame_n_out) &&
    kind_ff == AHL_RD_CTRL |-> !reg_select_out)
    else $error("select not low with control read strobe");

  tied_write_a: assert property (tie_sel_in && !write_frame_n_out
    |-> !reg_select_out)
    else $error("write frame with select high in tied wiring");

  refuse_ctrl_a: assert property (take && tie_sel_in &&
    cmd_kind_in == AHL_RD_CTRL |=> cmd_err_out && state_ff == AHL_IDLE)
    else $error("control read not refused in tied wiring");

  msb_order_a: assert property (state_ff == AHL_SHIFT && is_wr &&
    bit_cnt_ff < LAST_BIT |->
    sdata_out == word_ff[LAST_BIT - `AHL_CNT_W'(1) - bit_cnt_ff])
    else $error("write bit out of order");

  full_word_a: assert property (word_finish_s |->
    bit_cnt_ff == LAST_BIT - `AHL_CNT_W'(1)
    ##2 read_frame_n_out && write_frame_n_out)
    else $error("frame ended before 24 bits");

  gap_levels_a: assert property (state_ff == AHL_GAP ##1 state_ff == AHL_GAP
    |-> read_frame_n_out && write_frame_n_out && !sclk_out)
    else $error("strobe low or clock high in segment gap");

  drive_frame_a: assert property (!sdata_oe_n_out |-> !write_frame_n_out)
    else $error("data driven outside a write frame");

endmodule

// *** test/ahl_dev_model.sv ***
// behavioural converter serial port: clock comes from the host
module ahl_dev_model (
  // bench side controls
  input  wire logic        mclk_in,
  input  wire logic        load_in,
  input  wire logic        cal_mode_in,
  input  wire logic [23:0] word_in,
  // converter pins
  input  wire logic        sclk_in,
  input  wire logic        read_frame_n_in,
  input  wire logic        write_frame_n_in,
  input  wire logic        reg_select_in,
  input  wire logic        host_sd_in,
  input  wire logic        host_oe_n_in,
  output logic             sdata_out,
  output logic             word_ready_n_out,
  // register contents for the bench
  output logic [23:0]      ctrl_out,
  output logic [23:0]      cal_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] sh;
  logic [23:0] wsh;
  logic [23:0] data_q;
  logic        src_data;
  int          rcnt;
  int          wcnt;

  // power-up contents, no word pending
  initial begin
    sdata_out = 1'b0;
    word_ready_n_out = 1'b1;
    ctrl_out = 24'h0;
    cal_out = 24'h0;
    data_q = 24'h0;
    sh = 24'h0;
    wsh = 24'h0;
    src_data = 1'b0;
    rcnt = 0;
    wcnt = 0;
  end
  // a fresh conversion result lowers word ready
  always @(posedge mclk_in) begin
    if (load_in) begin
      data_q <= word_in;
      word_ready_n_out <= 1'b0;
    end
  end
  // source chosen once per word, so a split read keeps its place
  always @(negedge read_frame_n_in) begin
    #1; // select moves on the same host edge as the strobe; let it settle first
    if (rcnt == 0) begin
      sh = !reg_select_in ? ctrl_out : (cal_mode_in ? cal_out : data_q);
      src_data = reg_select_in && !cal_mode_in;
    end
    sdata_out = sh[23 - rcnt];
  end
  // each falling clock moves one bit on; the last one ends the word
  always @(negedge sclk_in) begin
    if (!read_frame_n_in) begin
      rcnt = rcnt + 1;
      if (rcnt == 24) begin
        rcnt = 0;
        sdata_out = ~sdata_out;
        if (src_data) word_ready_n_out = 1'b1;
      end else begin
        sdata_out = sh[23 - rcnt];
      end
    end
  end
  // a released line must not keep showing the last bit
  always @(posedge read_frame_n_in) sdata_out = ~sdata_out;
  // write bits taken at the high level, msb first; garbage if host not driving
  always @(posedge sclk_in) begin
    if (!write_frame_n_in) begin
      wsh = {wsh[22:0], host_oe_n_in ? ~sdata_out : host_sd_in};
      wcnt = wcnt + 1;
      if (wcnt == 24) begin
        wcnt = 0;
        if (!reg_select_in) ctrl_out = wsh;
        else cal_out = wsh;
      end
    end
  end
endmodule

// *** test/adc_ext_clock_serial_host_link_tb.sv ***
module adc_ext_clock_serial_host_link_tb
  import ahl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        tie_sel = 1'b0;
  logic        lsb_first = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        load = 1'b0;
  logic        cal_mode = 1'b0;
  logic [1:0]  seg = 2'h0;
  logic [2:0]  kind = 3'h0;
  logic [23:0] wdata = 24'h0;
  logic [23:0] word = 24'h0;
  logic        ready, valid, err, sclk, rfn, wfn, sel, wrdy_n, sd_dev, sd_host, oe_n;
  logic [23:0] rdata, ctrl_q, cal_q;
  logic        g_err, g_vld;
  int          falls;
  int          fail_count = 0;
  int          checks = 0;
  int          cycles = 0;
  int          overlap = 0;

  always #20 mclk = ~mclk;

  ahl_host dut_u (.mclk_in(mclk), .rst_in(rst), .ce_in(1'b1), .tie_sel_in(tie_sel),
    .lsb_first_in(lsb_first), .seg_bytes_in(seg), .cmd_valid_in(cmd_valid),
    .cmd_ready_out(ready), .cmd_kind_in(kind), .cmd_wdata_in(wdata), .rdata_out(rdata),
    .rdata_valid_out(valid), .cmd_err_out(err), .sclk_out(sclk), .read_frame_n_out(rfn),
    .write_frame_n_out(wfn), .reg_select_out(sel), .word_ready_n_in(wrdy_n),
    .sdata_in(sd_dev), .sdata_out(sd_host), .sdata_oe_n_out(oe_n));

  ahl_dev_model dev_u (.mclk_in(mclk), .load_in(load), .cal_mode_in(cal_mode),
    .word_in(word), .sclk_in(sclk), .read_frame_n_in(rfn), .write_frame_n_in(wfn),
    .reg_select_in(sel), .host_sd_in(sd_host), .host_oe_n_in(oe_n), .sdata_out(sd_dev),
    .word_ready_n_out(wrdy_n), .ctrl_out(ctrl_q), .cal_out(cal_q));

  task automatic test_done();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard: whole run needs well under this many cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      test_done();
    end
  end
  // both strobes low at once would corrupt the converter's frame
  always @(negedge mclk) if (rfn === 1'b0 && wfn === 1'b0) overlap++;

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // user words in lsb-first mode are reversed inside each byte
  function automatic logic [23:0] rev_bytes(input logic [23:0] w);
    for (int i = 0; i < 24; i++) rev_bytes[i] = w[(i / 8) * 8 + 7 - i % 8];
  endfunction

  // one command: present, wait for take, then follow it to the end
  task automatic do_cmd(input logic [2:0] k, input logic [23:0] w);
    logic pr;
    logic pw;
    pr = 1'b1;
    pw = 1'b1;
    g_err = 1'b0;
    g_vld = 1'b0;
    falls = 0;
    @(posedge mclk);
    kind <= k;
    wdata <= w;
    cmd_valid <= 1'b1;
    @(negedge mclk);
    for (int i = 0; i < 5000 && ready !== 1'b1; i++) @(negedge mclk);
    @(posedge mclk);
    cmd_valid <= 1'b0;
    for (int i = 0; i < 20000; i++) begin
      @(negedge mclk);
      g_err |= (err === 1'b1);
      g_vld |= (valid === 1'b1);
      if (pr && rfn === 1'b0) falls++;
      if (pw && wfn === 1'b0) falls++;
      pr = (rfn !== 1'b0);
      pw = (wfn !== 1'b0);
      if (ready === 1'b1 && i > 0) break;
    end
  endtask

  task automatic put_word(input logic [23:0] w);
    @(posedge mclk);
    word <= w;
    load <= 1'b1;
    @(posedge mclk);
    load <= 1'b0;
  endtask

  task automatic t_reset();
    @(negedge mclk);
    check(24'({rfn, wfn, sel, sclk, oe_n, ready}), 24'h3B);
    check(rdata, 24'h0);
    $display("test reset done");
  endtask

  task automatic t_ctrl();
    do_cmd(AHL_WR_CTRL, 24'hA5C31E);
    check(ctrl_q, 24'hA5C31E);
    check(24'(falls), 24'h1);
    do_cmd(AHL_RD_CTRL, 24'h0);
    check(24'({g_vld, g_err}), 24'h2);
    check(rdata, 24'hA5C31E);
    check(24'({rfn, wfn, sel, sclk}), 24'hE);
    $display("test ctrl done");
  endtask

  task automatic t_cal();
    cal_mode <= 1'b1;
    do_cmd(AHL_WR_CAL, 24'h5A0F96);
    check(cal_q, 24'h5A0F96);
    check(ctrl_q, 24'hA5C31E);
    do_cmd(AHL_RD_CAL, 24'h0);
    check(24'(g_vld), 24'h1);
    check(rdata, 24'h5A0F96);
    cal_mode <= 1'b0;
    $display("test cal done");
  endtask

  // host must hold the read strobe until word ready falls
  task automatic t_wait();
    fork
      do_cmd(AHL_RD_DATA, 24'h0);
      begin
        repeat (60) @(negedge mclk);
        check(24'(rfn), 24'h1);
        put_word(24'hC3817E);
      end
    join
    check(rdata, 24'hC3817E);
    check(24'(wrdy_n), 24'h1);
    $display("test wait done");
  endtask

  // one, two and three byte segments, reads and writes
  task automatic t_seg();
    for (int s = 1; s <= 3; s++) begin
      @(posedge mclk);
      seg <= 2'(s);
      put_word(24'h13579B + 24'(s));
      do_cmd(AHL_RD_DATA, 24'h0);
      check(24'(falls), (s == 1) ? 24'h3 : (s == 2) ? 24'h2 : 24'h1);
      check(rdata, 24'h13579B + 24'(s));
      check(24'(wrdy_n), 24'h1);
      do_cmd(AHL_WR_CTRL, 24'h2468A0 + 24'(s));
      check(24'(falls), (s == 1) ? 24'h3 : (s == 2) ? 24'h2 : 24'h1);
      check(ctrl_q, 24'h2468A0 + 24'(s));
    end
    @(posedge mclk);
    seg <= 2'h0;
    $display("test seg done");
  endtask

  task automatic t_lsb();
    @(posedge mclk);
    lsb_first <= 1'b1;
    do_cmd(AHL_WR_CTRL, 24'h0180C3);
    check(ctrl_q, rev_bytes(24'h0180C3));
    do_cmd(AHL_RD_CTRL, 24'h0);
    check(rdata, 24'h0180C3);
    @(posedge mclk);
    lsb_first <= 1'b0;
    $display("test lsb done");
  endtask

  // strobe wired to select: ctrl reads and cal writes are refused
  task automatic t_tie();
    logic [2:0] bad [5];
    bad = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
    @(posedge mclk);
    tie_sel <= 1'b1;
    cal_mode <= 1'b1;
    foreach (bad[i]) begin
      do_cmd(bad[i], 24'hFFFFFF);
      check(24'({g_err, g_vld}), 24'h2);
      check(24'(falls), 24'h0);
    end
    check(cal_q, 24'h5A0F96);
    do_cmd(AHL_WR_CTRL, 24'h3C3C5A);
    check(ctrl_q, 24'h3C3C5A);
    do_cmd(AHL_RD_CAL, 24'h0);
    check(rdata, 24'h5A0F96);
    @(posedge mclk);
    tie_sel <= 1'b0;
    cal_mode <= 1'b0;
    $display("test tie done");
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_ctrl();
    t_cal();
    t_wait();
    t_seg();
    t_lsb();
    t_tie();
    check(24'(overlap), 24'h0);
    test_done();
  end
endmodule
